// file: ccm_regs.sv
// Contract
// - Five-bit input gain, 01000 is 0 dB.
// - Input gain top bit mutes channel.
// - Mic register bit 6 adds boost.
// - Input gains reset 8008h mono, 8808h stereo.
// - Record select holds left/right three-bit sources.
// - Record gain four-bit fields, reset 8000h.
// - Record gain top bit mutes its channels.
// - Mono source and microphone choice bits.
// - Loopback routes ADC to DAC internally.
// - Audio powerdown low byte is read-only readiness.
// - Codec ready only when fully operational; here it needs only the strap taken and the reference ready.
// - Each powerdown bit controls its own section; audio bits 12-14 and modem bits 12-15 drive nothing here.
// - Variable and double rate unsupported.
// - Extended audio status read-only, mic ready.
// - Mic converter off independent of PCM ADC.
// - Modem ident write warm-resets modem registers.
// - Two-bit codec role field.
// - Only line one capability reported.
// - Legacy modem bits in audio powerdown ignored.
// - Pin section off tri-states, slot twelve invalid.
// - Modem status low byte read-only readiness.
// - Modem status high byte writable powerdowns.
// - Access through command and status slots.
// - Index zero write resets audio registers.
// - Reserved bits ignore writes, read zero.
module ccm_regs #(
    parameter int SAMPLE_W = 18
) (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic cmd_valid_i,
    input wire ccm_pkg::ccm_cmd_type cmd_i,
    output logic stat_valid_o,
    output ccm_pkg::ccm_stat_type stat_o,
    output logic codec_ready_o,
    input wire ccm_pkg::ccm_ready_type ready_i,
    input wire logic [1:0] codec_role_i,
    input wire logic link_active_i,
    input wire logic [SAMPLE_W-1:0] adc_sample_i,
    input wire logic [SAMPLE_W-1:0] link_dac_sample_i,
    output logic [SAMPLE_W-1:0] dac_sample_o,
    output ccm_pkg::ccm_analog_type analog_o,
    output ccm_pkg::ccm_power_type power_o,
    output logic pin_outputs_off_o,
    output logic slot12_valid_o
);
    import ccm_pkg::*;

    // ==========================================================
    // Register state
    logic [15:0] mono_gain_r;
    logic [15:0] mic_gain_r;
    logic [15:0] rec_sel_r;
    logic [15:0] rec_gain_st_r;
    logic [15:0] rec_gain_mic_r;
    logic [15:0] gp_r;
    logic [7:0] audio_off_r;
    logic mic_off_r;
    logic [7:0] modem_off_r;
    logic [1:0] role_r;
    logic role_taken_r;
    logic codec_ready_r;
    logic stat_valid_r;
    ccm_stat_type stat_r;
    logic [SAMPLE_W-1:0] dac_sample_r;
    ccm_analog_type analog_r;
    ccm_power_type power_r;

    logic wr;
    logic audio_rst;
    logic modem_rst;
    ccm_power_type power_nxt;

    assign wr = cmd_valid_i && !cmd_i.read;
    assign audio_rst = wr && (cmd_i.index == IDX_AUDIO_RESET);
    assign modem_rst = wr && (cmd_i.index == IDX_MODEM_ID);

    function automatic logic wr_hit(input logic [6:0] idx);
        wr_hit = wr && (cmd_i.index == idx);
    endfunction

    // ==========================================================
    // Audio registers
    // Reserved bits are masked off on write so they read back as zero.
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mono_gain_r <= RST_MONO_GAIN;
            mic_gain_r <= RST_MONO_GAIN;
            rec_sel_r <= RST_REC_SEL;
            rec_gain_st_r <= RST_REC_GAIN;
            rec_gain_mic_r <= RST_REC_GAIN;
            gp_r <= RST_ZERO;
            audio_off_r <= 8'h00;
            mic_off_r <= 1'b0;
        end else if (audio_rst) begin
            mono_gain_r <= RST_MONO_GAIN;
            mic_gain_r <= RST_MONO_GAIN;
            rec_sel_r <= RST_REC_SEL;
            rec_gain_st_r <= RST_REC_GAIN;
            rec_gain_mic_r <= RST_REC_GAIN;
            gp_r <= RST_ZERO;
            audio_off_r <= 8'h00;
            mic_off_r <= 1'b0;
        end else begin
            if (wr_hit(IDX_MONO_GAIN)) begin
                mono_gain_r <= cmd_i.data & 16'h801F;
            end
            if (wr_hit(IDX_MIC_GAIN)) begin
                mic_gain_r <= cmd_i.data & 16'h805F;
            end
            if (wr_hit(IDX_REC_SEL)) begin
                rec_sel_r <= cmd_i.data & 16'h0707;
            end
            if (wr_hit(IDX_REC_GAIN_ST)) begin
                rec_gain_st_r <= cmd_i.data & 16'h8F0F;
            end
            if (wr_hit(IDX_REC_GAIN_MIC)) begin
                rec_gain_mic_r <= cmd_i.data & 16'h800F;
            end
            if (wr_hit(IDX_GP_CTRL)) begin
                gp_r <= cmd_i.data & 16'h0380;
            end
            if (wr_hit(IDX_AUDIO_PWR)) begin
                // Low byte is status and is never stored.
                audio_off_r <= cmd_i.data[15:8];
            end
            if (wr_hit(IDX_EXT_AUDIO)) begin
                // Rate enables are not kept: the modes do not exist here.
                mic_off_r <= cmd_i.data[MIC_OFF_BIT];
            end
        end
    end

    // ==========================================================
    // Modem registers
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            modem_off_r <= RST_MODEM_OFF;
        end else if (modem_rst) begin
            modem_off_r <= RST_MODEM_OFF;
        end else if (wr_hit(IDX_MODEM_PWR)) begin
            modem_off_r <= cmd_i.data[15:8];
        end
    end

    // The role strap is caught by the first clock after reset release.
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            role_r <= 2'b00;
            role_taken_r <= 1'b0;
        end else if (!role_taken_r) begin
            role_r <= codec_role_i;
            role_taken_r <= 1'b1;
        end
    end

    // Ready is raised once the strap is held and the reference is up.
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            codec_ready_r <= 1'b0;
        end else begin
            codec_ready_r <= role_taken_r && ready_i.reference;
        end
    end

    // ==========================================================
    // Readback
    function automatic logic [15:0] read_word(input logic [6:0] idx);
        logic [15:0] v;
        v = 16'h0000;
        unique case (idx)
            IDX_MONO_GAIN: v = mono_gain_r;
            IDX_MIC_GAIN: v = mic_gain_r;
            IDX_REC_SEL: v = rec_sel_r;
            IDX_REC_GAIN_ST: v = rec_gain_st_r;
            IDX_REC_GAIN_MIC: v = rec_gain_mic_r;
            IDX_GP_CTRL: v = gp_r;
            IDX_AUDIO_PWR: begin
                // Bit 4 (legacy modem ready) stays zero.
                v = {audio_off_r, 4'h0, ready_i.reference, ready_i.mixer,
                    ready_i.dac, ready_i.adc};
            end
            IDX_EXT_AUDIO: begin
                v[MIC_OFF_BIT] = mic_off_r;
                v[MIC_READY_BIT] = ready_i.mic_adc && !mic_off_r;
            end
            IDX_MODEM_ID: begin
                v[ROLE_LO_BIT+1:ROLE_LO_BIT] = role_r;
                v[LINE_ONE_BIT] = 1'b1;
            end
            IDX_MODEM_PWR: begin
                v = {modem_off_r, 4'h0,
                    ready_i.line_one_dac && !modem_off_r[3],
                    ready_i.line_one_adc && !modem_off_r[2],
                    ready_i.modem_reference && !modem_off_r[1],
                    ready_i.pin_section && !modem_off_r[0]};
            end
            default: v = 16'h0000;
        endcase
        read_word = v;
    endfunction

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            stat_valid_r <= 1'b0;
            stat_r <= '0;
        end else begin
            stat_valid_r <= cmd_valid_i && cmd_i.read;
            if (cmd_valid_i && cmd_i.read) begin
                stat_r.index <= cmd_i.index;
                stat_r.data <= read_word(cmd_i.index);
            end
        end
    end

    // ==========================================================
    // Analog controls
    // Mute bits travel alongside the codes; the analog side forces
    // minus infinity whenever a mute bit is set.
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            analog_r <= '0;
        end else begin
            analog_r.mono_mute <= mono_gain_r[MUTE_BIT];
            analog_r.mono_gain <= mono_gain_r[4:0];
            analog_r.mic_mute <= mic_gain_r[MUTE_BIT];
            analog_r.mic_gain <= mic_gain_r[4:0];
            analog_r.mic_boost <= mic_gain_r[BOOST_BIT];
            analog_r.left_source_code <= rec_sel_r[10:8];
            analog_r.right_source_code <= rec_sel_r[2:0];
            analog_r.rec_mute <= rec_gain_st_r[MUTE_BIT];
            analog_r.rec_left_gain <= rec_gain_st_r[11:8];
            analog_r.rec_right_gain <= rec_gain_st_r[3:0];
            analog_r.rec_mic_mute <= rec_gain_mic_r[MUTE_BIT];
            analog_r.rec_mic_gain <= rec_gain_mic_r[3:0];
            analog_r.mono_out_mic <= gp_r[MONO_SRC_BIT];
            analog_r.microphone_choice <= gp_r[MIC_CHOICE_BIT];
        end
    end

    // ==========================================================
    // Power controls
    always_comb begin
        power_nxt.pcm_adc_off = audio_off_r[0];
        power_nxt.pcm_dac_off = audio_off_r[1];
        power_nxt.mixer_off = audio_off_r[2];
        power_nxt.reference_off = audio_off_r[3];
        // Legacy modem off (bit 7 of the high byte) drives nothing.
        power_nxt.mic_converter_off = mic_off_r;
        power_nxt.pin_section_off = modem_off_r[0];
        power_nxt.modem_reference_off = modem_off_r[1];
        power_nxt.line_one_adc_off = modem_off_r[2];
        power_nxt.line_one_dac_off = modem_off_r[3];
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            power_r <= '0;
        end else begin
            power_r <= power_nxt;
        end
    end

    // ==========================================================
    // Loopback path
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dac_sample_r <= '0;
        end else if (gp_r[LOOPBACK_BIT]) begin
            dac_sample_r <= adc_sample_i;
        end else begin
            dac_sample_r <= link_dac_sample_i;
        end
    end

    assign stat_valid_o = stat_valid_r;
    assign stat_o = stat_r;
    assign codec_ready_o = codec_ready_r;
    assign dac_sample_o = dac_sample_r;
    assign analog_o = analog_r;
    assign power_o = power_r;
    assign pin_outputs_off_o = power_r.pin_section_off;
    assign slot12_valid_o = link_active_i && !power_r.pin_section_off;
endmodule // ccm_regs

// file: ccm_pkg.sv
package ccm_pkg;
    // ==========================================================
    // Register indices
    localparam logic [6:0] IDX_AUDIO_RESET = 7'h00;
    localparam logic [6:0] IDX_MONO_GAIN = 7'h0C;
    localparam logic [6:0] IDX_MIC_GAIN = 7'h0E;
    localparam logic [6:0] IDX_REC_SEL = 7'h1A;
    localparam logic [6:0] IDX_REC_GAIN_ST = 7'h1C;
    localparam logic [6:0] IDX_REC_GAIN_MIC = 7'h1E;
    localparam logic [6:0] IDX_GP_CTRL = 7'h20;
    localparam logic [6:0] IDX_AUDIO_PWR = 7'h26;
    localparam logic [6:0] IDX_EXT_AUDIO = 7'h2A;
    localparam logic [6:0] IDX_MODEM_ID = 7'h3C;
    localparam logic [6:0] IDX_MODEM_PWR = 7'h3E;
    // ==========================================================
    // Reset values
    localparam logic [15:0] RST_MONO_GAIN = 16'h8008;
    localparam logic [15:0] RST_STEREO_GAIN = 16'h8808;
    localparam logic [15:0] RST_REC_SEL = 16'h0000;
    localparam logic [15:0] RST_REC_GAIN = 16'h8000;
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic [7:0] RST_MODEM_OFF = 8'h00;
    // ==========================================================
    // Field positions
    localparam int MUTE_BIT = 15;
    localparam int BOOST_BIT = 6;
    localparam int MONO_SRC_BIT = 9;
    localparam int MIC_CHOICE_BIT = 8;
    localparam int LOOPBACK_BIT = 7;
    localparam int MIC_OFF_BIT = 14;
    localparam int MIC_READY_BIT = 9;
    localparam int LINE_ONE_BIT = 0;
    localparam int ROLE_LO_BIT = 14;

    typedef struct packed {
        logic read;
        logic [6:0] index;
        logic [15:0] data;
    } ccm_cmd_type;

    typedef struct packed {
        logic [6:0] index;
        logic [15:0] data;
    } ccm_stat_type;

    // Live readiness of each analog subsection.
    typedef struct packed {
        logic reference;
        logic mixer;
        logic dac;
        logic adc;
        logic mic_adc;
        logic pin_section;
        logic modem_reference;
        logic line_one_adc;
        logic line_one_dac;
    } ccm_ready_type;

    typedef struct packed {
        logic mono_mute;
        logic [4:0] mono_gain;
        logic mic_mute;
        logic [4:0] mic_gain;
        logic mic_boost;
        logic [2:0] left_source_code;
        logic [2:0] right_source_code;
        logic rec_mute;
        logic [3:0] rec_left_gain;
        logic [3:0] rec_right_gain;
        logic rec_mic_mute;
        logic [3:0] rec_mic_gain;
        logic mono_out_mic;
        logic microphone_choice;
    } ccm_analog_type;

    typedef struct packed {
        logic pcm_adc_off;
        logic pcm_dac_off;
        logic mixer_off;
        logic reference_off;
        logic mic_converter_off;
        logic pin_section_off;
        logic modem_reference_off;
        logic line_one_adc_off;
        logic line_one_dac_off;
    } ccm_power_type;
endpackage

// file: ccm_regs_monitor.sv
module ccm_regs_monitor (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic cmd_valid_i,
    input wire ccm_pkg::ccm_cmd_type cmd_i,
    input wire logic stat_valid_o,
    input wire ccm_pkg::ccm_stat_type stat_o,
    input wire logic codec_ready_o,
    input wire ccm_pkg::ccm_ready_type ready_i,
    input wire logic link_active_i,
    input wire ccm_pkg::ccm_analog_type analog_o,
    input wire ccm_pkg::ccm_power_type power_o,
    input wire logic pin_outputs_off_o,
    input wire logic slot12_valid_o
);
    timeunit 1ns;
    timeprecision 100ps;
    import ccm_pkg::*;
    // ==========================================================
    // Command slot sequences
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    sequence s_read;
        cmd_valid_i && cmd_i.read;
    endsequence
    sequence s_write(logic [6:0] idx);
        cmd_valid_i && !cmd_i.read && cmd_i.index == idx;
    endsequence
    // ==========================================================
    // Assertions
    a_read_answer: assert property (s_read |=>
        stat_valid_o && stat_o.index == $past(cmd_i.index))
        else $error("read answer missing or wrong index");
    a_no_stray_answer: assert property (!(cmd_valid_i && cmd_i.read) |=> !stat_valid_o)
        else $error("answer without a read");
    a_audio_ready_live: assert property (stat_valid_o &&
        stat_o.index == IDX_AUDIO_PWR |->
        stat_o.data[7:0] == {4'h0, $past(ready_i.reference), $past(ready_i.mixer),
        $past(ready_i.dac), $past(ready_i.adc)}) else $error("audio readiness byte wrong");
    a_ext_audio_status: assert property (stat_valid_o &&
        stat_o.index == IDX_EXT_AUDIO |->
        stat_o.data[9:0] == {$past(ready_i.mic_adc) & ~stat_o.data[14], 9'h000})
        else $error("extended audio status wrong");
    a_modem_ready_live: assert property (stat_valid_o && stat_o.index == IDX_MODEM_PWR |->
        stat_o.data[7:0] == {4'h0, $past(ready_i.line_one_dac) & ~stat_o.data[11],
        $past(ready_i.line_one_adc) & ~stat_o.data[10],
        $past(ready_i.modem_reference) & ~stat_o.data[9],
        $past(ready_i.pin_section) & ~stat_o.data[8]}) else $error("modem readiness wrong");
    a_modem_caps: assert property (stat_valid_o && stat_o.index == IDX_MODEM_ID |->
        stat_o.data[13:0] == 14'h0001) else $error("modem capability bits wrong");
    a_ready_needs_ref: assert property (!ready_i.reference |=> !codec_ready_o)
        else $error("codec ready without reference");
    a_slot12_gate: assert property (slot12_valid_o == (link_active_i && !pin_outputs_off_o)
        && pin_outputs_off_o == power_o.pin_section_off) else $error("slot 12 gating wrong");
    a_warm_reset: assert property (s_write(IDX_MODEM_ID) |-> ##2 !power_o.pin_section_off
        && !power_o.modem_reference_off && !power_o.line_one_adc_off
        && !power_o.line_one_dac_off) else $error("warm reset left modem powered down");
    a_audio_reset: assert property (s_write(IDX_AUDIO_RESET) ##1 !cmd_valid_i |-> ##1
        analog_o.mono_mute && analog_o.mono_gain == 5'h08 && analog_o.mic_mute
        && analog_o.mic_gain == 5'h08) else $error("audio reset did not restore gains");
endmodule // ccm_regs_monitor

bind ccm_regs ccm_regs_monitor ccm_regs_monitor_i (.ref_clk_i, .reset_n_i, .cmd_valid_i,
    .cmd_i, .stat_valid_o, .stat_o, .codec_ready_o, .ready_i, .link_active_i, .analog_o,
    .power_o, .pin_outputs_off_o, .slot12_valid_o);

// file: ccm_link_model.sv
module ccm_link_model (
    input wire logic ref_clk_i,
    input wire logic stat_valid_i,
    input wire ccm_pkg::ccm_stat_type stat_i,
    output logic cmd_valid_o,
    output ccm_pkg::ccm_cmd_type cmd_o
);
    timeunit 1ns;
    timeprecision 100ps;
    import ccm_pkg::*;
    logic read_seen;
    logic [15:0] read_data;
    initial begin
        cmd_valid_o = 1'b0;
        cmd_o = '0;
    end
    // ==========================================================
    // One command word per frame
    // The answer stands for one cycle only, so it is caught at the first falling edge.
    task automatic send(input logic rd, input logic [6:0] idx, input logic [15:0] data);
        @(negedge ref_clk_i);
        cmd_valid_o = 1'b1;
        cmd_o = {rd, idx, data};
        @(negedge ref_clk_i);
        cmd_valid_o = 1'b0;
        cmd_o = ~cmd_o;
        read_seen = stat_valid_i && stat_i.index == idx;
        read_data = stat_i.data;
    endtask
endmodule // ccm_link_model

// file: ccm_regs_test.sv
module ccm_regs_test;
    timeunit 1ns;
    timeprecision 100ps;
    import ccm_pkg::*;
    logic ref_clk_i = 1'b0, reset_n_i = 1'b0, link_active_i = 1'b1;
    logic cmd_valid_i, stat_valid_o, codec_ready_o, pin_outputs_off_o, slot12_valid_o;
    ccm_cmd_type cmd_i;
    ccm_stat_type stat_o;
    ccm_ready_type ready_i = 9'h1FF;
    logic [1:0] codec_role_i = 2'h1;
    logic [17:0] adc_sample_i = 18'h2A5A5, link_dac_sample_i = 18'h15A5A, dac_sample_o;
    ccm_analog_type analog_o;
    ccm_power_type power_o;
    int mismatches = 0, checked = 0, cycles = 0;
    logic [6:0] idx_tab [6] = '{IDX_MONO_GAIN, IDX_MIC_GAIN, IDX_REC_SEL, IDX_REC_GAIN_ST,
        IDX_REC_GAIN_MIC, IDX_GP_CTRL};
    logic [15:0] rst_tab [6] = '{16'h8008, 16'h8008, 16'h0000, 16'h8000, 16'h8000, 16'h0000};
    logic [15:0] mask_tab [6] = '{16'h801F, 16'h805F, 16'h0707, 16'h8F0F, 16'h800F, 16'h0380};
    logic [4:0] gain_tab [3] = '{5'h00, 5'h08, 5'h1F};
    logic [15:0] pwr_tab [5] = '{16'h0100, 16'h0200, 16'h0400, 16'h0800, 16'h8000};
    logic [3:0] pwr_exp [5] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h0};
    ccm_regs ccm_regs_i (.ref_clk_i, .reset_n_i, .cmd_valid_i, .cmd_i, .stat_valid_o, .stat_o,
        .codec_ready_o, .ready_i, .codec_role_i, .link_active_i, .adc_sample_i,
        .link_dac_sample_i, .dac_sample_o, .analog_o, .power_o, .pin_outputs_off_o,
        .slot12_valid_o);
    ccm_link_model ccm_link_model_i (.ref_clk_i, .stat_valid_i(stat_valid_o),
        .stat_i(stat_o), .cmd_valid_o(cmd_valid_i), .cmd_o(cmd_i));
    always #2.5 ref_clk_i = ~ref_clk_i;
    // ==========================================================
    // Checking and closing
    task automatic fail(input string msg);
        mismatches++;
        $display("mismatch at %0t: %s", $time, msg);
    endtask
    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp) fail($sformatf("%s got %h expected %h", what, got, exp));
    endtask
    task automatic cmp1(input logic got, input logic exp, input string what);
        checked++;
        if (got !== exp) fail($sformatf("%s got %b expected %b", what, got, exp));
    endtask
    task automatic cmp_smp(input logic [17:0] got, input logic [17:0] exp);
        checked++;
        if (got !== exp) fail($sformatf("sample got %h expected %h", got, exp));
    endtask
    task automatic finish_test;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // The whole sequence needs well under a thousand cycles; this only cuts a hang.
    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail("timeout");
            finish_test();
        end
    end
    // ==========================================================
    // Register access
    task automatic wr(input logic [6:0] idx, input logic [15:0] data);
        ccm_link_model_i.send(1'b0, idx, data);
    endtask
    task automatic rd(input logic [6:0] idx, input logic [15:0] exp);
        ccm_link_model_i.send(1'b1, idx, 16'h0000);
        cmp1(ccm_link_model_i.read_seen, 1'b1, "answer");
        cmp16(ccm_link_model_i.read_data, exp, $sformatf("index %h", idx));
    endtask
    // ==========================================================
    // Scenarios
    initial begin
        repeat (12) @(negedge ref_clk_i);
        reset_n_i = 1'b1;
        repeat (2) @(negedge ref_clk_i);
        cmp1(codec_ready_o, 1'b1, "codec ready");
        rd(IDX_AUDIO_PWR, 16'h000F);
        for (int i = 0; i < 6; i++) begin
            rd(idx_tab[i], rst_tab[i]);
            wr(idx_tab[i], 16'hFFFF);
            rd(idx_tab[i], mask_tab[i]);
        end
        cmp_smp(dac_sample_o, adc_sample_i);
        cmp16({analog_o.mono_mute, analog_o.mic_mute, analog_o.mono_out_mic,
            analog_o.microphone_choice, 12'h0}, 16'hF000, "mutes and selects");
        cmp16({analog_o.rec_mute, 3'h0, analog_o.rec_left_gain, analog_o.rec_mic_mute, 3'h0,
            analog_o.rec_right_gain}, 16'h8F8F, "record gains");
        wr(IDX_MIC_GAIN, 16'h0048);
        wr(IDX_REC_GAIN_MIC, 16'h000F);
        wr(IDX_GP_CTRL, 16'h0000);
        @(negedge ref_clk_i);
        cmp16({analog_o.mic_mute, analog_o.mic_boost, analog_o.mono_out_mic,
            analog_o.microphone_choice, 7'h0, analog_o.mic_gain}, 16'h4008, "mic");
        cmp16({analog_o.rec_mic_mute, 11'h0, analog_o.rec_mic_gain}, 16'h000F, "rec");
        cmp_smp(dac_sample_o, link_dac_sample_i);
        foreach (gain_tab[i]) begin
            wr(IDX_MONO_GAIN, {11'h0, gain_tab[i]});
            @(negedge ref_clk_i);
            cmp16({analog_o.mono_mute, 10'h0, analog_o.mono_gain}, {11'h0, gain_tab[i]},
                "mono gain");
        end
        for (int c = 0; c < 8; c++) begin
            wr(IDX_REC_SEL, {5'h0, 3'(c), 5'h0, 3'(7 - c)});
            @(negedge ref_clk_i);
            cmp16({10'h0, analog_o.left_source_code, analog_o.right_source_code},
                {10'h0, 3'(c), 3'(7 - c)}, "sources");
        end
        ready_i = 9'h15F;
        wr(IDX_AUDIO_PWR, 16'hFFFF);
        rd(IDX_AUDIO_PWR, 16'hFF0A);
        foreach (pwr_tab[i]) begin
            wr(IDX_AUDIO_PWR, pwr_tab[i]);
            @(negedge ref_clk_i);
            cmp16({power_o.pcm_adc_off, power_o.pcm_dac_off, power_o.mixer_off,
                power_o.reference_off, 12'h0}, {pwr_exp[i], 12'h0}, "power");
        end
        wr(IDX_EXT_AUDIO, 16'hFFFF);
        rd(IDX_EXT_AUDIO, 16'h4000);
        cmp16({power_o.mic_converter_off, power_o.pcm_adc_off, 14'h0}, 16'h8000, "mic off");
        wr(IDX_EXT_AUDIO, 16'h0000);
        rd(IDX_EXT_AUDIO, 16'h0200);
        ready_i.reference = 1'b0;
        repeat (2) @(negedge ref_clk_i);
        cmp1(codec_ready_o, 1'b0, "codec ready dropped");
        ready_i.reference = 1'b1;
        wr(IDX_MODEM_PWR, 16'hFFFF);
        rd(IDX_MODEM_PWR, 16'hFF00);
        cmp16({power_o.pin_section_off, power_o.modem_reference_off, power_o.line_one_adc_off,
            power_o.line_one_dac_off, 12'h0}, 16'hF000, "modem power");
        cmp1(pin_outputs_off_o, 1'b1, "pins off");
        cmp1(slot12_valid_o, 1'b0, "slot 12 valid");
        wr(IDX_MODEM_PWR, 16'h0100);
        wr(IDX_AUDIO_RESET, 16'h1234);
        rd(IDX_MONO_GAIN, 16'h8008);
        rd(IDX_AUDIO_PWR, 16'h000A);
        rd(IDX_MODEM_PWR, 16'h010E);
        wr(IDX_MONO_GAIN, 16'h0005);
        wr(IDX_MODEM_ID, 16'hFFFF);
        rd(IDX_MODEM_PWR, 16'h000F);
        cmp16({power_o.pin_section_off, power_o.modem_reference_off, power_o.line_one_adc_off,
            power_o.line_one_dac_off, 12'h0}, 16'h0000, "modem power reset");
        rd(IDX_MONO_GAIN, 16'h0005);
        cmp1(slot12_valid_o, 1'b1, "slot 12 valid");
        link_active_i = 1'b0;
        #1 cmp1(slot12_valid_o, 1'b0, "slot 12 idle link");
        rd(IDX_MODEM_ID, 16'h4001);
        rd(7'h02, 16'h0000);
        finish_test();
    end
endmodule // ccm_regs_test
